// ---- hdl/cpuio_regs.svh ----
// opcode encodings, masks, reset values and vectors of the decoder
`ifndef CPUIO_REGS_SVH
`define CPUIO_REGS_SVH

// ***********************************************************************
// single opcodes
// ***********************************************************************
`define CPUIO_OP_NOP 10'h000
`define CPUIO_OP_P1IN 10'h261
`define CPUIO_OP_P2IN 10'h262
`define CPUIO_OP_P3IN 10'h263
`define CPUIO_OP_YINC 10'h013
`define CPUIO_OP_P2OUT 10'h222
`define CPUIO_OP_P3OUT 10'h223
`define CPUIO_OP_OR 10'h019
`define CPUIO_OP_PWROFF 10'h002
`define CPUIO_OP_PWREN 10'h05b
`define CPUIO_OP_ROTR 10'h01d
`define CPUIO_OP_CCLR 10'h006
`define CPUIO_OP_CSET 10'h007
`define CPUIO_OP_DCLR 10'h014
`define CPUIO_OP_RET 10'h044
`define CPUIO_OP_RETSK 10'h045
`define CPUIO_OP_RETI 10'h046

// ***********************************************************************
// opcode groups with immediate fields
// ***********************************************************************
`define CPUIO_MASK_IMM4 10'h3f0
`define CPUIO_MASK_IMM8 10'h300
`define CPUIO_MASK_IMM2 10'h3fc
`define CPUIO_GRP_ALOAD 10'h070
`define CPUIO_GRP_XYLOAD 10'h300
`define CPUIO_GRP_ZLOAD 10'h048
`define CPUIO_GRP_BCLR 10'h04c
`define CPUIO_GRP_BSET 10'h05c

// ***********************************************************************
// reset values and vectors
// ***********************************************************************
`define CPUIO_RST_PC 12'h000
`define CPUIO_RST_SP 3'h7
`define CPUIO_RST_NIB 4'h0
`define CPUIO_RST_PORTD 6'h3f
`define CPUIO_INT_VEC 12'h000
`define CPUIO_PORTD_MAX 4'h5

`endif

// ---- hdl/cpuio_pkg.sv ----
// types shared by the decoder core
package cpuio_pkg;

  typedef enum logic [0:0] {
    ST_EXEC,
    ST_RET2
  } cpuio_state_type;

  typedef struct packed {
    cpuio_state_type state;
    logic [11:0] pc;
    logic [2:0] sp;
    logic [7:0][11:0] stack;
    logic [3:0] acc;
    logic carry;
    logic [3:0] x;
    logic [3:0] y;
    logic [1:0] z;
    logic [3:0] b;
    logic skip;
    logic aload_run;
    logic xyload_run;
    logic pwroff_en;
    logic backup;
    logic [1:0] port2;
    logic [1:0] port3;
    logic [5:0] portd;
    logic [3:0] sv_x;
    logic [3:0] sv_y;
    logic [1:0] sv_z;
    logic sv_carry;
    logic sv_skip;
    logic sv_aload_run;
    logic sv_xyload_run;
    logic [3:0] sv_acc;
    logic [3:0] sv_b;
  } cpuio_state_struct_type;

endpackage : cpuio_pkg

// ---- hdl/cpuio_ram.sv ----
// data ram, 256 nibbles, registered read with write-first bypass
`timescale 1ns/100ps
module cpuio_ram (
  input wire logic clk_i,
  input wire logic [7:0] raddr_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [3:0] wdata_i,
  output logic [3:0] rdata_o
);

  logic [3:0] mem_ff [0:255];
  logic [3:0] rdata_ff;

  // ***********************************************************************
  // write port and registered read
  // ***********************************************************************
  // bypass keeps a read-modify-write on the same nibble coherent
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_ff <= wdata_i;
    end else begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule : cpuio_ram

// ---- hdl/cpuio_core.sv ----
// instruction decode and execute for the i/o, load and return subset
`timescale 1ns/100ps
`include "cpuio_regs.svh"
module cpuio_core
  import cpuio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] instr_i,
  input wire logic int_entry_i,
  input wire logic wake_i,
  input wire logic [3:0] port1_i,
  input wire logic [1:0] port2_i,
  input wire logic [1:0] port3_i,
  output logic [11:0] pc_o,
  output logic [3:0] acc_o,
  output logic carry_o,
  output logic [3:0] x_o,
  output logic [3:0] y_o,
  output logic [1:0] z_o,
  output logic skip_o,
  output logic [1:0] port2_o,
  output logic [1:0] port3_o,
  output logic [5:0] portd_o,
  output logic backup_o
);

  cpuio_state_struct_type st_ff;
  cpuio_state_struct_type nxt_st;
  logic [3:0] ram_rdata;
  logic ram_we;
  logic [3:0] ram_wdata;
  logic is_aload;
  logic is_xyload;
  logic is_zload;
  logic is_bclr;
  logic is_bset;
  logic [3:0] bit_mask;
  logic run_skip;
  logic [11:0] stack_top;
  logic [2:0] sp_push;
  logic [2:0] sp_pop;
  logic ret_skip;
  logic [7:0] dp_now;
  logic [7:0] dp_next;

  // ***********************************************************************
  // opcode group decode
  // ***********************************************************************
  assign is_aload = (instr_i & `CPUIO_MASK_IMM4) == `CPUIO_GRP_ALOAD;
  assign is_xyload = (instr_i & `CPUIO_MASK_IMM8) == `CPUIO_GRP_XYLOAD;
  assign is_zload = (instr_i & `CPUIO_MASK_IMM2) == `CPUIO_GRP_ZLOAD;
  assign is_bclr = (instr_i & `CPUIO_MASK_IMM2) == `CPUIO_GRP_BCLR;
  assign is_bset = (instr_i & `CPUIO_MASK_IMM2) == `CPUIO_GRP_BSET;
  assign bit_mask = 4'h1 << instr_i[1:0];

  // an acc or x/y load that follows a load of its own kind is not executed
  assign run_skip = (is_aload && st_ff.aload_run) ||
                    (is_xyload && st_ff.xyload_run);

  // ***********************************************************************
  // stack and pointers
  // ***********************************************************************
  // push pre-increments, so the top entry always sits at the pointer;
  // eight entries only, a ninth push wraps onto the oldest one
  assign sp_push = st_ff.sp + 3'h1;
  assign sp_pop = st_ff.sp - 3'h1;
  assign stack_top = st_ff.stack[st_ff.sp];
  assign dp_now = {st_ff.x, st_ff.y};
  assign dp_next = {nxt_st.x, nxt_st.y};

  // ***********************************************************************
  // return decode
  // ***********************************************************************
  // pc holds over ret and retsk, so their second cycle sees the same word again; reti loads it at once
  assign ret_skip = (instr_i == `CPUIO_OP_RETSK);

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    nxt_st = st_ff;
    ram_we = 1'b0;
    ram_wdata = ram_rdata;
    if (!rst_n_i) begin
      nxt_st.state = ST_EXEC;
      nxt_st.pc = `CPUIO_RST_PC;
      nxt_st.sp = `CPUIO_RST_SP;
      nxt_st.stack = '0;
      nxt_st.acc = `CPUIO_RST_NIB;
      nxt_st.carry = 1'b0;
      nxt_st.x = `CPUIO_RST_NIB;
      nxt_st.y = `CPUIO_RST_NIB;
      nxt_st.z = 2'h0;
      nxt_st.b = `CPUIO_RST_NIB;
      nxt_st.skip = 1'b0;
      nxt_st.aload_run = 1'b0;
      nxt_st.xyload_run = 1'b0;
      nxt_st.pwroff_en = 1'b0;
      nxt_st.backup = 1'b0;
      nxt_st.port2 = 2'h0;
      nxt_st.port3 = 2'h0;
      nxt_st.portd = `CPUIO_RST_PORTD;
      nxt_st.sv_x = `CPUIO_RST_NIB;
      nxt_st.sv_y = `CPUIO_RST_NIB;
      nxt_st.sv_z = 2'h0;
      nxt_st.sv_carry = 1'b0;
      nxt_st.sv_skip = 1'b0;
      nxt_st.sv_aload_run = 1'b0;
      nxt_st.sv_xyload_run = 1'b0;
      nxt_st.sv_acc = `CPUIO_RST_NIB;
      nxt_st.sv_b = `CPUIO_RST_NIB;
    end else if (st_ff.backup) begin
      // ram back-up: everything frozen until the wake pulse
      if (wake_i) begin
        nxt_st.backup = 1'b0;
      end
    end else begin
      case (st_ff.state)
        ST_EXEC: begin
          if (int_entry_i) begin
            // interrupt entry: push pc, snapshot state for the return
            nxt_st.sp = sp_push;
            nxt_st.stack[sp_push] = st_ff.pc;
            nxt_st.pc = `CPUIO_INT_VEC;
            nxt_st.sv_x = st_ff.x;
            nxt_st.sv_y = st_ff.y;
            nxt_st.sv_z = st_ff.z;
            nxt_st.sv_carry = st_ff.carry;
            nxt_st.sv_skip = st_ff.skip;
            nxt_st.sv_aload_run = st_ff.aload_run;
            nxt_st.sv_xyload_run = st_ff.xyload_run;
            nxt_st.sv_acc = st_ff.acc;
            nxt_st.sv_b = st_ff.b;
            nxt_st.skip = 1'b0;
            nxt_st.aload_run = 1'b0;
            nxt_st.xyload_run = 1'b0;
            nxt_st.pwroff_en = 1'b0;
          end else begin
            nxt_st.pc = st_ff.pc + 12'h001;
            nxt_st.skip = 1'b0;
            nxt_st.pwroff_en = 1'b0;
            // run flags follow the opcode even when it is skipped
            nxt_st.aload_run = is_aload;
            nxt_st.xyload_run = is_xyload;
            if (st_ff.skip || run_skip) begin
              // skipped word acts as a no-operation
            end else if (is_aload) begin
              nxt_st.acc = instr_i[3:0];
            end else if (is_xyload) begin
              nxt_st.x = instr_i[7:4];
              nxt_st.y = instr_i[3:0];
            end else if (is_zload) begin
              nxt_st.z = instr_i[1:0];
            end else if (is_bclr) begin
              ram_we = 1'b1;
              ram_wdata = ram_rdata & ~bit_mask;
            end else if (is_bset) begin
              ram_we = 1'b1;
              ram_wdata = ram_rdata | bit_mask;
            end else begin
              case (instr_i)
                `CPUIO_OP_P1IN: begin
                  nxt_st.acc = port1_i;
                end
                `CPUIO_OP_P2IN: begin
                  nxt_st.acc = {2'h0, port2_i};
                end
                `CPUIO_OP_P3IN: begin
                  nxt_st.acc = {2'h0, port3_i};
                end
                `CPUIO_OP_YINC: begin
                  nxt_st.y = st_ff.y + 4'h1;
                  nxt_st.skip = (nxt_st.y == 4'h0);
                end
                `CPUIO_OP_P2OUT: begin
                  nxt_st.port2 = st_ff.acc[1:0];
                end
                `CPUIO_OP_P3OUT: begin
                  nxt_st.port3 = st_ff.acc[1:0];
                end
                `CPUIO_OP_OR: begin
                  nxt_st.acc = st_ff.acc | ram_rdata;
                end
                `CPUIO_OP_PWREN: begin
                  nxt_st.pwroff_en = 1'b1;
                end
                `CPUIO_OP_PWROFF: begin
                  // without the enable right before, a no-operation
                  nxt_st.backup = st_ff.pwroff_en;
                end
                `CPUIO_OP_ROTR: begin
                  nxt_st.acc = {st_ff.carry, st_ff.acc[3:1]};
                  nxt_st.carry = st_ff.acc[0];
                end
                `CPUIO_OP_CCLR: begin
                  nxt_st.carry = 1'b0;
                end
                `CPUIO_OP_CSET: begin
                  nxt_st.carry = 1'b1;
                end
                `CPUIO_OP_DCLR: begin
                  // out-of-range y is left to software; ignored here
                  if (st_ff.y <= `CPUIO_PORTD_MAX) begin
                    nxt_st.portd[st_ff.y[2:0]] = 1'b0;
                  end
                end
                `CPUIO_OP_RET: begin
                  // pc held: the fetch in the second cycle is discarded
                  nxt_st.pc = st_ff.pc;
                  nxt_st.state = ST_RET2;
                end
                `CPUIO_OP_RETSK: begin
                  // skip is decided from the refetched word
                  nxt_st.pc = st_ff.pc;
                  nxt_st.state = ST_RET2;
                end
                `CPUIO_OP_RETI: begin
                  nxt_st.pc = stack_top;
                  nxt_st.sp = sp_pop;
                  nxt_st.x = st_ff.sv_x;
                  nxt_st.y = st_ff.sv_y;
                  nxt_st.z = st_ff.sv_z;
                  nxt_st.carry = st_ff.sv_carry;
                  nxt_st.skip = st_ff.sv_skip;
                  nxt_st.aload_run = st_ff.sv_aload_run;
                  nxt_st.xyload_run = st_ff.sv_xyload_run;
                  nxt_st.acc = st_ff.sv_acc;
                  nxt_st.b = st_ff.sv_b;
                end
                default: begin
                  // other opcodes are outside this block: no-operation
                end
              endcase
            end
          end
        end
        ST_RET2: begin
          // second cycle of a return; the fetched word is discarded
          nxt_st.state = ST_EXEC;
          nxt_st.pc = stack_top;
          nxt_st.sp = sp_pop;
          nxt_st.skip = ret_skip;
        end
        default: begin
          nxt_st.state = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // ***********************************************************************
  // data ram
  // ***********************************************************************
  // read address is the next pointer so the nibble is ready in time
  cpuio_ram u_ram (
    .clk_i(clk_i),
    .raddr_i(dp_next),
    .we_i(ram_we),
    .waddr_i(dp_now),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign pc_o = st_ff.pc;
  assign acc_o = st_ff.acc;
  assign carry_o = st_ff.carry;
  assign x_o = st_ff.x;
  assign y_o = st_ff.y;
  assign z_o = st_ff.z;
  assign skip_o = st_ff.skip;
  assign port2_o = st_ff.port2;
  assign port3_o = st_ff.port3;
  assign portd_o = st_ff.portd;
  assign backup_o = st_ff.backup;

endmodule : cpuio_core

// ---- tb/cpuio_rom_model.sv ----
// program rom model answering the core's fetch address
`timescale 1ns/100ps
module cpuio_rom_model (
  input wire logic [11:0] addr_i,
  output logic [9:0] data_o
);
  logic [9:0] mem [0:4095];
  // ********
  // read
  // ********
  // combinational, since the core takes the word in the cycle pc shows
  assign data_o = mem[addr_i];
  // unused words read as no-operation
  task automatic fill(input logic [9:0] w[$]);
    for (int i = 0; i < 4096; i++) begin
      mem[i] = (i < w.size()) ? w[i] : 10'h000;
    end
  endtask : fill
  task automatic put(input int a, input logic [9:0] w);
    mem[a] = w;
  endtask : put
endmodule : cpuio_rom_model

// ---- tb/cpuio_core_properties.sv ----
// concurrent checks on the decoder core ports
`timescale 1ns/100ps
`include "cpuio_regs.svh"
module cpuio_core_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] instr_i,
  input wire logic int_entry_i,
  input wire logic wake_i,
  input wire logic [3:0] port1_i,
  input wire logic [1:0] port2_i,
  input wire logic [1:0] port3_i,
  input wire logic [11:0] pc_o,
  input wire logic [3:0] acc_o,
  input wire logic carry_o,
  input wire logic [3:0] x_o,
  input wire logic [3:0] y_o,
  input wire logic [1:0] z_o,
  input wire logic skip_o,
  input wire logic [1:0] port2_o,
  input wire logic [1:0] port3_o,
  input wire logic [5:0] portd_o,
  input wire logic backup_o
);
  typedef struct packed {
    logic ret2;
  } cpuio_chk_state_type;
  cpuio_chk_state_type chk_ff;
  cpuio_chk_state_type nxt_chk;
  logic exec;
  // ********
  // helper
  // ********
  // second return cycle ignores its word, so it must not count as executed
  assign exec = rst_n_i && !backup_o && !skip_o && !int_entry_i &&
    !chk_ff.ret2;
  always_comb begin
    nxt_chk.ret2 = exec && (instr_i == `CPUIO_OP_RET ||
      instr_i == `CPUIO_OP_RETSK);
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chk_ff <= '0;
    end else begin
      chk_ff <= nxt_chk;
    end
  end
  // ********
  // checks
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_aload_run;
    exec && (instr_i & `CPUIO_MASK_IMM4) == `CPUIO_GRP_ALOAD ##1
    !int_entry_i && (instr_i & `CPUIO_MASK_IMM4) == `CPUIO_GRP_ALOAD;
  endsequence
  // rti may restore a pending run, so it cannot open a fresh load
  sequence s_xy_fresh;
    exec && instr_i != `CPUIO_OP_RETI &&
    (instr_i & `CPUIO_MASK_IMM8) != `CPUIO_GRP_XYLOAD ##1
    exec && (instr_i & `CPUIO_MASK_IMM8) == `CPUIO_GRP_XYLOAD;
  endsequence
  sequence s_pwr_enter;
    exec && instr_i == `CPUIO_OP_PWREN ##1 exec &&
    instr_i == `CPUIO_OP_PWROFF;
  endsequence
  chk_port23_load: assert property (
    exec && (instr_i == `CPUIO_OP_P2IN || instr_i == `CPUIO_OP_P3IN) |=>
    acc_o == {2'h0, ($past(instr_i[0]) ? $past(port3_i) : $past(port2_i))}
  ) else $error("port 2/3 load wrong");
  chk_yinc_skip: assert property (
    exec && instr_i == `CPUIO_OP_YINC |=>
    y_o == $past(y_o) + 4'h1 && skip_o == (y_o == 4'h0)
  ) else $error("y increment wrong");
  chk_aload_run: assert property (
    s_aload_run |=> $stable(acc_o)
  ) else $error("repeated acc load executed");
  chk_xy_load: assert property (
    s_xy_fresh |=> {x_o, y_o} == $past(instr_i[7:0])
  ) else $error("x/y load wrong");
  chk_nop_only_pc: assert property (
    exec && instr_i == `CPUIO_OP_NOP |=> pc_o == $past(pc_o) + 12'h1 &&
    $stable({acc_o, carry_o, x_o, y_o, z_o, port2_o, port3_o, portd_o})
  ) else $error("no-operation changed state");
  chk_port_out: assert property (
    exec && (instr_i == `CPUIO_OP_P2OUT || instr_i == `CPUIO_OP_P3OUT) |=>
    ($past(instr_i[0]) ? port3_o : port2_o) == $past(acc_o[1:0])
  ) else $error("port output wrong");
  chk_pwr_enter: assert property (
    s_pwr_enter |=> backup_o
  ) else $error("back-up not entered");
  chk_rotate_carry: assert property (
    exec && instr_i == `CPUIO_OP_ROTR |=> {carry_o, acc_o} ==
    {$past(acc_o[0]), $past(carry_o), $past(acc_o[3:1])}
  ) else $error("rotate wrong");
  chk_carry_force: assert property (
    exec && (instr_i == `CPUIO_OP_CCLR || instr_i == `CPUIO_OP_CSET) |=>
    carry_o == $past(instr_i[0]) && $stable(acc_o)
  ) else $error("carry set/clear wrong");
  chk_return_pc: assert property (
    exec && (instr_i == `CPUIO_OP_RET || instr_i == `CPUIO_OP_RETSK) |=>
    $stable(pc_o) ##1 skip_o == $past(instr_i[0], 2)
  ) else $error("return timing or skip wrong");
endmodule : cpuio_core_properties

bind cpuio_core cpuio_core_properties i_cpuio_core_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
  .int_entry_i(int_entry_i), .wake_i(wake_i), .port1_i(port1_i),
  .port2_i(port2_i), .port3_i(port3_i), .pc_o(pc_o), .acc_o(acc_o),
  .carry_o(carry_o), .x_o(x_o), .y_o(y_o), .z_o(z_o), .skip_o(skip_o),
  .port2_o(port2_o), .port3_o(port3_o), .portd_o(portd_o),
  .backup_o(backup_o)
);

// ---- tb/cpuio_core_tb_top.sv ----
// self-checking bench for the decoder core
`timescale 1ns/100ps
module cpuio_core_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic int_entry_i = 1'b0;
  logic wake_i = 1'b0;
  logic [3:0] port1_i = 4'h0;
  logic [1:0] port2_i = 2'h0;
  logic [1:0] port3_i = 2'h0;
  logic [9:0] instr_i;
  logic [11:0] pc_o;
  logic [3:0] acc_o, x_o, y_o;
  logic [1:0] z_o, port2_o, port3_o;
  logic carry_o, skip_o, backup_o;
  logic [5:0] portd_o;
  int err_count = 0;
  int n_compared = 0;
  always #25 clk_i = ~clk_i;
  cpuio_core i_cpuio_core (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_i(instr_i), .int_entry_i(int_entry_i), .wake_i(wake_i),
    .port1_i(port1_i), .port2_i(port2_i), .port3_i(port3_i),
    .pc_o(pc_o), .acc_o(acc_o), .carry_o(carry_o), .x_o(x_o), .y_o(y_o),
    .z_o(z_o), .skip_o(skip_o), .port2_o(port2_o), .port3_o(port3_o),
    .portd_o(portd_o), .backup_o(backup_o));
  cpuio_rom_model i_cpuio_rom_model (.addr_i(pc_o), .data_o(instr_i));
  // ********
  // helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // reset each run, so pc starts at the first word of the program
  task automatic start(input logic [9:0] w[$]);
    i_cpuio_rom_model.fill(w);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
  endtask : start
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : step
  // one more word runs before the interrupt is taken
  task automatic irq;
    @(posedge clk_i);
    int_entry_i <= 1'b1;
    @(posedge clk_i);
    int_entry_i <= 1'b0;
    @(negedge clk_i);
  endtask : irq
  // ********
  // scenarios
  // ********
  task automatic t_inputs;
    @(posedge clk_i);
    port1_i <= 4'ha;
    port2_i <= 2'h3;
    port3_i <= 2'h2;
    start('{10'h007, 10'h261, 10'h262, 10'h263});
    check(portd_o, 6'h3f);
    step(2);
    check({carry_o, acc_o}, 5'h1a);
    step(1);
    check(acc_o, 4'h3);
    step(1);
    check(acc_o, 4'h2);
  endtask : t_inputs
  task automatic t_loads;
    start('{10'h07f, 10'h070, 10'h3ff, 10'h300, 10'h04b, 10'h000});
    step(2);
    check(acc_o, 4'hf);
    step(2);
    check({x_o, y_o}, 8'hff);
    step(1);
    check(z_o, 2'h3);
    step(1);
    check({pc_o, acc_o}, 16'h006f);
  endtask : t_loads
  task automatic t_yinc;
    start('{10'h30f, 10'h013, 10'h075, 10'h013});
    step(2);
    check({y_o, skip_o}, 5'h01);
    step(1);
    check({acc_o, skip_o}, 5'h00);
    step(1);
    check({y_o, skip_o}, 5'h02);
  endtask : t_yinc
  task automatic t_out_rot;
    start('{10'h07e, 10'h222, 10'h007, 10'h01d, 10'h223, 10'h007, 10'h006});
    step(2);
    check({port2_o, port3_o}, 4'h8);
    step(2);
    check({carry_o, acc_o}, 5'h0f);
    step(1);
    check(port3_o, 2'h3);
    step(1);
    check(carry_o, 1'b1);
    step(1);
    check(carry_o, 1'b0);
  endtask : t_out_rot
  task automatic t_ram;
    start('{10'h300, 10'h04c, 10'h04d, 10'h04e, 10'h04f, 10'h05c, 10'h05e,
      10'h078, 10'h019, 10'h04c, 10'h070, 10'h019});
    step(9);
    check(acc_o, 4'hd);
    step(3);
    check(acc_o, 4'h4);
  endtask : t_ram
  task automatic t_portd;
    start('{10'h303, 10'h014, 10'h000, 10'h305, 10'h014});
    step(2);
    check(portd_o, 6'h37);
    step(3);
    check(portd_o, 6'h17);
  endtask : t_portd
  task automatic t_power;
    start('{10'h002, 10'h05b, 10'h000, 10'h002, 10'h05b, 10'h002});
    step(1);
    check(backup_o, 1'b0);
    step(3);
    check(backup_o, 1'b0);
    step(5);
    check({backup_o, pc_o}, 13'h1006);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(negedge clk_i);
    check(backup_o, 1'b0);
  endtask : t_power
  task automatic t_returns;
    start('{10'h07a, 10'h007, 10'h351});
    step(5);
    i_cpuio_rom_model.fill('{10'h070, 10'h300, 10'h006, 10'h046});
    irq();
    check(pc_o, 12'h000);
    step(4);
    check({pc_o, carry_o, acc_o, x_o, y_o}, 25'h00d_a51);
    i_cpuio_rom_model.put(0, 10'h045);
    irq();
    step(1);
    check(pc_o, 12'h000);
    step(1);
    check({pc_o, skip_o}, 13'h00f);
    i_cpuio_rom_model.put(0, 10'h044);
    irq();
    step(1);
    check(pc_o, 12'h000);
    step(1);
    check({pc_o, skip_o}, 13'h010);
  endtask : t_returns
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    t_inputs();
    t_loads();
    t_yinc();
    t_out_rot();
    t_ram();
    t_portd();
    t_power();
    t_returns();
    end_sim();
  end
endmodule : cpuio_core_tb_top
